// ==== logic/rsp_pkg.sv ====
`default_nettype none
package rsp_pkg;
	// ------------------------------------------------------------
	// Clock and baud source
	// ------------------------------------------------------------
	localparam int unsigned MCLK_KHZ_X10 = 400000;
	localparam int unsigned SRC_KHZ_X10 = 24576;
	localparam int unsigned ACC_W = 19;
	localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(SRC_KHZ_X10);
	localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(MCLK_KHZ_X10);
	localparam logic [15:0] DIV_110 = 16'h0574;
	localparam logic [15:0] DIV_300 = 16'h0200;
	localparam logic [15:0] DIV_600 = 16'h0100;
	localparam logic [15:0] DIV_1200 = 16'h0080;
	localparam logic [15:0] DIV_2400 = 16'h0040;
	localparam logic [15:0] DIV_4800 = 16'h0020;
	localparam logic [15:0] DIV_9600 = 16'h0010;
	localparam logic [15:0] DIV_RST = DIV_9600;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W = 2;
	localparam logic [1:0] REG_DATA = 2'h0;
	localparam logic [1:0] REG_CTRL = 2'h1;
	localparam logic [1:0] REG_DIVL = 2'h2;
	localparam logic [1:0] REG_DIVH = 2'h3;
	// ------------------------------------------------------------
	// Mode, command and status fields
	// ------------------------------------------------------------
	localparam int unsigned MODE_FAC = 0;
	localparam int unsigned MODE_LEN = 2;
	localparam int unsigned MODE_PEN = 4;
	localparam int unsigned MODE_EVEN = 5;
	localparam int unsigned MODE_STOP = 6;
	localparam logic [1:0] FAC_X16 = 2'h2;
	localparam logic [1:0] FAC_X64 = 2'h3;
	localparam logic [7:0] TICKS_X1 = 8'h01;
	localparam logic [7:0] TICKS_X16 = 8'h10;
	localparam logic [7:0] TICKS_X64 = 8'h40;
	localparam logic [1:0] STOP_15 = 2'h2;
	localparam logic [1:0] STOP_2 = 2'h3;
	localparam int unsigned CMD_TXEN = 0;
	localparam int unsigned CMD_XEN = 1;
	localparam int unsigned CMD_RXEN = 2;
	localparam int unsigned CMD_BRK = 3;
	localparam int unsigned CMD_ERST = 4;
	localparam int unsigned CMD_IRST = 6;
	localparam logic [7:0] CMD_PULSE = 8'h50;
	localparam int unsigned ST_TXRDY = 0;
	localparam int unsigned ST_RXRDY = 1;
	localparam int unsigned ST_TXEMP = 2;
	localparam int unsigned ST_PE = 3;
	localparam int unsigned ST_OE = 4;
	localparam int unsigned ST_FE = 5;
	localparam int unsigned ST_BRK = 6;
	localparam int unsigned ST_LERR = 7;
	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		TX_IDLE = 3'h0,
		TX_START = 3'h1,
		TX_DATA = 3'h3,
		TX_PAR = 3'h2,
		TX_STOP = 3'h6
	} rsp_tx_t;
	typedef enum logic [2:0] {
		RX_IDLE = 3'h0,
		RX_START = 3'h1,
		RX_DATA = 3'h3,
		RX_PAR = 3'h2,
		RX_STOP = 3'h6
	} rsp_rx_t;
endpackage
`default_nettype wire

// ==== logic/rsp_baud_gen.sv ====
`timescale 1ns/10ps
`default_nettype none
module rsp_baud_gen
	import rsp_pkg::*;
#(
	parameter int unsigned DIV_W = 16
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [DIV_W-1:0] divisor,
	input wire logic restart,
	output logic tick,
	output logic baud_generator_output
);
	typedef struct packed {
		logic [ACC_W-1:0] acc;
		logic [DIV_W:0] cnt;
		logic out;
		logic tick;
	} rsp_bg_t;
	rsp_bg_t s_q, s_d;
	logic src_en;
	logic reload;
	logic [ACC_W-1:0] acc_sum;
	logic [DIV_W:0] n;

	if (DIV_W < 2 || DIV_W > 16) begin : g_chk
		$error("rsp_baud_gen: DIV_W out of range");
	end

	// ------------------------------------------------------------
	// Source enable and square wave counter
	// ------------------------------------------------------------
	always_comb begin
		acc_sum = s_q.acc + ACC_STEP;
		src_en = acc_sum >= ACC_MOD;
		n = (divisor == '0) ? {1'b1, {DIV_W{1'b0}}} : {1'b0, divisor};
		reload = s_q.cnt <= (DIV_W+1)'(1);
		s_d = s_q;
		s_d.tick = 1'b0;
		s_d.acc = src_en ? acc_sum - ACC_MOD : acc_sum;
		if (restart) begin
			s_d.cnt = n;
			s_d.out = 1'b1;
		end else if (src_en) begin
			s_d.cnt = reload ? n : s_q.cnt - 1'b1;
			s_d.out = s_d.cnt > (n >> 1);
			s_d.tick = reload;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;
	assign baud_generator_output = s_q.out;
endmodule // rsp_baud_gen
`default_nettype wire

// ==== logic/rsp_serial_port.sv ====
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module rsp_serial_port
	import rsp_pkg::*;
#(
	parameter int unsigned DATA_W = 8
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DATA_W-1:0] rdata,
	input wire logic rxd_in,
	output logic txd_out,
	output logic xmit_enable_out,
	output logic set_ready_out,
	output logic carrier_detect_out,
	input wire logic ready_in,
	input wire logic far_unit_ok_in,
	input wire logic paper_exhausted_in,
	input wire logic equip_check_switch,
	input wire logic carrier_hold_switch,
	input wire logic paper_polarity_switch,
	output logic baud_generator_output
);
	typedef struct packed {
		logic mode_ok;
		logic [7:0] mode;
		logic [7:0] cmd;
		logic [15:0] div;
		logic div_load;
		logic [7:0] thr;
		logic thr_full;
		rsp_tx_t txs;
		logic [7:0] tsh;
		logic [2:0] tbit;
		logic [7:0] tcnt;
		logic tpar;
		logic txd;
		logic txo;
		logic [7:0] rbuf;
		logic rfull;
		rsp_rx_t rxs;
		logic [7:0] rsh;
		logic [2:0] rbit;
		logic [7:0] rcnt;
		logic rpar;
		logic pe;
		logic oe;
		logic fe;
		logic brk;
		logic lerr;
		logic cd;
		logic dsr;
		logic [7:0] rdata;
	} rsp_st_t;

	localparam rsp_st_t ST_RST = '{default: '0, txs: TX_IDLE, rxs: RX_IDLE,
		div: DIV_RST, txd: 1'b1, txo: 1'b1, dsr: 1'b1};

	rsp_st_t s_q, s_d;
	logic tick;
	logic tx_step;
	logic rx_step;
	logic wr_data;
	logic rd_data;
	logic irst;
	logic [7:0] fac;
	logic [2:0] last;
	logic [7:0] rx_word;
	logic [7:0] status;

	if (DATA_W != 8) begin : g_chk
		$error("rsp_serial_port: DATA_W must be 8");
	end

	// ------------------------------------------------------------
	// Mode decoding
	// ------------------------------------------------------------
	function automatic logic [7:0] fac_ticks(input logic [7:0] m);
		unique case (m[MODE_FAC +: 2])
			FAC_X16: fac_ticks = TICKS_X16;
			FAC_X64: fac_ticks = TICKS_X64;
			default: fac_ticks = TICKS_X1;
		endcase
	endfunction

	function automatic logic [7:0] stop_ticks(input logic [7:0] m);
		logic [7:0] f;
		f = fac_ticks(m);
		unique case (m[MODE_STOP +: 2])
			STOP_15: stop_ticks = f + (f >> 1);
			STOP_2: stop_ticks = f << 1;
			default: stop_ticks = f;
		endcase
	endfunction

	function automatic logic [2:0] last_bit(input logic [7:0] m);
		last_bit = 3'h4 + {1'b0, m[MODE_LEN +: 2]};
	endfunction

	function automatic logic par_bit(input logic [7:0] d, input logic [7:0] m);
		logic [7:0] mask;
		mask = 8'hff >> (2'h3 - m[MODE_LEN +: 2]);
		par_bit = (^(d & mask)) ^ ~m[MODE_EVEN];
	endfunction

	// ------------------------------------------------------------
	// Baud generator
	// ------------------------------------------------------------
	rsp_baud_gen #(
		.DIV_W(16)
	) u_baud (
		.mclk(mclk),
		.rst(rst),
		.divisor(s_q.div),
		.restart(s_q.div_load),
		.tick(tick),
		.baud_generator_output(baud_generator_output)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.div_load = 1'b0;
		fac = fac_ticks(s_q.mode);
		last = last_bit(s_q.mode);
		rx_word = s_q.rsh >> (2'h3 - s_q.mode[MODE_LEN +: 2]);
		wr_data = wr && addr == REG_DATA;
		rd_data = rd && addr == REG_DATA;
		irst = wr && addr == REG_CTRL && s_q.mode_ok && wdata[CMD_IRST];
		status = '0;
		status[ST_TXRDY] = !s_q.thr_full;
		status[ST_RXRDY] = s_q.rfull;
		status[ST_TXEMP] = !s_q.thr_full && s_q.txs == TX_IDLE;
		status[ST_PE] = s_q.pe;
		status[ST_OE] = s_q.oe;
		status[ST_FE] = s_q.fe;
		status[ST_BRK] = s_q.brk;
		status[ST_LERR] = s_q.lerr;
		// Register writes
		if (wr) begin
			unique case (addr)
				REG_DATA: begin
					s_d.thr = wdata;
					s_d.thr_full = 1'b1;
				end
				REG_CTRL: begin
					if (!s_q.mode_ok) begin
						s_d.mode = wdata;
						s_d.mode_ok = 1'b1;
					end else begin
						s_d.cmd = wdata & ~CMD_PULSE;
						if (wdata[CMD_ERST]) begin
							s_d.pe = 1'b0;
							s_d.oe = 1'b0;
							s_d.fe = 1'b0;
							s_d.lerr = 1'b0;
						end
					end
				end
				REG_DIVL: begin
					s_d.div[7:0] = wdata;
					s_d.div_load = 1'b1;
				end
				REG_DIVH: begin
					s_d.div[15:8] = wdata;
					s_d.div_load = 1'b1;
				end
			endcase
		end
		// Register reads
		if (rd) begin
			unique case (addr)
				REG_DATA: s_d.rdata = s_q.rbuf;
				REG_CTRL: s_d.rdata = status;
				REG_DIVL: s_d.rdata = s_q.div[7:0];
				REG_DIVH: s_d.rdata = s_q.div[15:8];
			endcase
		end
		if (rd_data) begin
			s_d.rfull = 1'b0;
		end
		// Transmitter
		tx_step = tick && s_q.tcnt <= 8'h01;
		if (tick && s_q.tcnt > 8'h01) begin
			s_d.tcnt = s_q.tcnt - 8'h01;
		end
		if (s_q.txs != TX_IDLE && equip_check_switch && !far_unit_ok_in) begin
			s_d.lerr = 1'b1;
		end
		if (s_q.txs != TX_IDLE && paper_polarity_switch == paper_exhausted_in) begin
			s_d.lerr = 1'b1;
		end
		unique case (s_q.txs)
			TX_IDLE: begin
				if (s_q.thr_full && s_q.cmd[CMD_TXEN] && ready_in) begin
					s_d.txs = TX_START;
					s_d.tsh = s_q.thr;
					s_d.tpar = par_bit(s_q.thr, s_q.mode);
					s_d.thr_full = wr_data;
					s_d.txd = 1'b0;
					s_d.tcnt = fac;
				end
			end
			TX_START: begin
				if (tx_step) begin
					s_d.txs = TX_DATA;
					s_d.tbit = '0;
					s_d.txd = s_q.tsh[0];
					s_d.tcnt = fac;
				end
			end
			TX_DATA: begin
				if (tx_step) begin
					s_d.tsh = s_q.tsh >> 1;
					s_d.tbit = s_q.tbit + 3'h1;
					s_d.tcnt = fac;
					if (s_q.tbit != last) begin
						s_d.txd = s_q.tsh[1];
					end else if (s_q.mode[MODE_PEN]) begin
						s_d.txs = TX_PAR;
						s_d.txd = s_q.tpar;
					end else begin
						s_d.txs = TX_STOP;
						s_d.txd = 1'b1;
						s_d.tcnt = stop_ticks(s_q.mode);
					end
				end
			end
			TX_PAR: begin
				if (tx_step) begin
					s_d.txs = TX_STOP;
					s_d.txd = 1'b1;
					s_d.tcnt = stop_ticks(s_q.mode);
				end
			end
			TX_STOP: begin
				if (tx_step) begin
					s_d.txs = TX_IDLE;
				end
			end
		endcase
		// Receiver
		rx_step = tick && s_q.rcnt <= 8'h01;
		if (tick && s_q.rcnt > 8'h01) begin
			s_d.rcnt = s_q.rcnt - 8'h01;
		end
		unique case (s_q.rxs)
			RX_IDLE: begin
				if (tick && !rxd_in && s_q.cmd[CMD_RXEN] && s_q.txs == TX_IDLE) begin
					s_d.rxs = RX_START;
					s_d.rcnt = (fac > 8'h01) ? fac >> 1 : 8'h01;
				end else if (tick && rxd_in) begin
					s_d.brk = 1'b0;
				end
			end
			RX_START: begin
				if (rx_step) begin
					s_d.rxs = rxd_in ? RX_IDLE : RX_DATA;
					s_d.rbit = '0;
					s_d.rcnt = fac;
				end
			end
			RX_DATA: begin
				if (rx_step) begin
					s_d.rsh = {rxd_in, s_q.rsh[7:1]};
					s_d.rbit = s_q.rbit + 3'h1;
					s_d.rcnt = fac;
					if (s_q.rbit == last) begin
						s_d.rxs = s_q.mode[MODE_PEN] ? RX_PAR : RX_STOP;
					end
				end
			end
			RX_PAR: begin
				if (rx_step) begin
					s_d.rpar = rxd_in;
					s_d.rxs = RX_STOP;
					s_d.rcnt = fac;
				end
			end
			RX_STOP: begin
				if (rx_step) begin
					s_d.rxs = RX_IDLE;
					s_d.rbuf = rx_word;
					s_d.rfull = 1'b1;
					if (s_q.rfull && !rd_data) begin
						s_d.oe = 1'b1;
					end
					if (s_q.mode[MODE_PEN] && s_q.rpar != par_bit(rx_word, s_q.mode)) begin
						s_d.pe = 1'b1;
					end
					if (!rxd_in) begin
						s_d.fe = 1'b1;
					end
					if (!rxd_in && rx_word == '0 && !(s_q.mode[MODE_PEN] && s_q.rpar)) begin
						s_d.brk = 1'b1;
					end
				end
			end
		endcase
		// Internal reset keeps the divisor
		if (irst) begin
			s_d = ST_RST;
			s_d.div = s_q.div;
		end
		// Line outputs
		s_d.txo = s_d.txd && !s_d.cmd[CMD_BRK];
		s_d.cd = carrier_hold_switch || s_d.txs != TX_IDLE;
		s_d.dsr = 1'b1;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_q <= ST_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
	assign txd_out = s_q.txo;
	assign xmit_enable_out = s_q.cmd[CMD_XEN];
	assign set_ready_out = s_q.dsr;
	assign carrier_detect_out = s_q.cd;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	a_dsr_always_on: assert property (set_ready_out)
		else $error("data set ready dropped");
	a_cd_hold_on: assert property (carrier_hold_switch |=> carrier_detect_out)
		else $error("carrier detect low with hold switch on");
	a_cd_idle_off: assert property ((s_q.txs == TX_IDLE && !$past(carrier_hold_switch)) |-> !carrier_detect_out)
		else $error("carrier detect high while idle");
	a_xen_follows: assert property ((wr && addr == REG_CTRL && s_q.mode_ok && !wdata[CMD_IRST])
		|=> xmit_enable_out == $past(wdata[CMD_XEN]))
		else $error("transmission enable not taken from command");
	a_ready_holds: assert property ((s_q.txs == TX_IDLE && !ready_in) |=> s_q.txs == TX_IDLE)
		else $error("character started with ready low");
	a_start_low: assert property ((s_q.txs == TX_START && !s_q.cmd[CMD_BRK]) |-> !txd_out)
		else $error("start bit not low");
	a_stop_high: assert property ((s_q.txs == TX_STOP && !s_q.cmd[CMD_BRK]) |-> txd_out)
		else $error("stop bit not high");
	a_break_low: assert property (s_q.cmd[CMD_BRK] |-> !txd_out)
		else $error("break not driven");
	a_equip_err: assert property ((s_q.txs != TX_IDLE && equip_check_switch && !far_unit_ok_in && !irst)
		|=> s_q.lerr)
		else $error("equipment error not flagged");
	a_paper_err: assert property ((s_q.txs != TX_IDLE && paper_polarity_switch == paper_exhausted_in
		&& !irst) |=> s_q.lerr)
		else $error("paper error not flagged");
	a_overrun_set: assert property ((s_q.rxs == RX_STOP && rx_step && s_q.rfull && !rd_data && !irst)
		|=> s_q.oe && s_q.rfull)
		else $error("overrun not flagged");
	a_half_duplex: assert property ((s_q.txs != TX_IDLE && s_q.rxs == RX_IDLE) |=> s_q.rxs == RX_IDLE)
		else $error("reception started while sending");
endmodule // rsp_serial_port
`default_nettype wire

// ==== test/rsp_far_end.sv ====
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Far-end serial peripheral
// ------------------------------------------------------------
module rsp_far_end #(
	parameter int BIT_CYC = 521
) (
	input wire logic mclk,
	input wire logic line_in,
	output logic line_out
);
	logic [7:0] got_data;
	logic got_par;
	logic got_stop;
	int got_cnt;
	initial begin
		line_out = 1'b1;
		got_cnt = 0;
	end
	// Catch frames: start, eight data LSB first, parity, stop
	always begin : catch_frame
		@(negedge line_in);
		repeat (BIT_CYC / 2) @(posedge mclk);
		if (line_in === 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYC) @(posedge mclk);
				got_data[i] = line_in;
			end
			repeat (BIT_CYC) @(posedge mclk);
			got_par = line_in;
			repeat (BIT_CYC) @(posedge mclk);
			got_stop = line_in;
			got_cnt++;
		end
	end
	// Send one frame, even parity unless flipped
	task automatic send(input logic [7:0] d, input logic flip, input logic stop);
		logic [10:0] f;
		f = {stop, ^d ^ flip, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge mclk);
			line_out <= f[i];
			repeat (BIT_CYC - 1) @(posedge mclk);
		end
		@(posedge mclk);
		line_out <= 1'b1;
	endtask
endmodule // rsp_far_end
`default_nettype wire

// ==== test/rsp_serial_port_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module rsp_serial_port_tb;
	import rsp_pkg::*;
	typedef struct {
		logic [15:0] div;
		int rate;
	} rsp_row_t;
	rsp_row_t rows [6] = '{'{DIV_300, 300}, '{DIV_600, 600}, '{DIV_1200, 1200},
		'{DIV_2400, 2400}, '{DIV_4800, 4800}, '{DIV_9600, 9600}};
	logic mclk, rst, wr, rd, rxd_in, txd_out, xmit_enable_out, set_ready_out;
	logic carrier_detect_out, ready_in, far_unit_ok_in, paper_exhausted_in;
	logic equip_check_switch, carrier_hold_switch, paper_polarity_switch;
	logic baud_generator_output;
	logic [ADDR_W-1:0] addr;
	logic [7:0] wdata, rdata, st;
	int num_errors, checks, per, hi, lo, c, k;
	rsp_serial_port #(.DATA_W(8)) dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .rxd_in(rxd_in), .txd_out(txd_out),
		.xmit_enable_out(xmit_enable_out), .set_ready_out(set_ready_out),
		.carrier_detect_out(carrier_detect_out), .ready_in(ready_in),
		.far_unit_ok_in(far_unit_ok_in), .paper_exhausted_in(paper_exhausted_in),
		.equip_check_switch(equip_check_switch), .carrier_hold_switch(carrier_hold_switch),
		.paper_polarity_switch(paper_polarity_switch),
		.baud_generator_output(baud_generator_output));
	rsp_far_end #(.BIT_CYC(521)) far (.mclk(mclk), .line_in(txd_out), .line_out(rxd_in));
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// ------------------------------------------------------------
	// Report and compare
	// ------------------------------------------------------------
	task automatic wrap_up;
		$display("Counts: %0d checks, %0d errors", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic fail(input string m);
		num_errors++;
		$display("ERROR at %0t: %s", $time, m);
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string m);
		checks++;
		if (got !== exp) fail(m);
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
		checks++;
		if (got !== exp) fail(m);
	endtask
	task automatic chk_span(input int got, input int lo_v, input int hi_v, input string m);
		checks++;
		if (got < lo_v || got > hi_v) fail(m);
	endtask
	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			fail("wait timed out");
			wrap_up();
		end
	endtask
	// ------------------------------------------------------------
	// Bus, baud and frame helpers
	// ------------------------------------------------------------
	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic set_div(input logic [15:0] d);
		wr_reg(REG_DIVL, d[7:0]);
		wr_reg(REG_DIVH, d[15:8]);
	endtask
	task automatic wait_bgo(input logic v, inout int n);
		int j;
		for (j = 0; j < 30000 && baud_generator_output !== v; j++) begin
			@(negedge mclk);
			n++;
		end
		tmo(j, 30000);
	endtask
	task automatic meas;
		c = 0;
		wait_bgo(1'b0, c);
		wait_bgo(1'b1, c);
		hi = 0;
		wait_bgo(1'b0, hi);
		per = hi;
		wait_bgo(1'b1, per);
	endtask
	task automatic tx_wait(input int n0, input logic [7:0] d, output logic [7:0] s);
		int j;
		for (j = 0; j < 3000 && txd_out !== 1'b0; j++) @(negedge mclk);
		tmo(j, 3000);
		chk_bit(carrier_detect_out, 1'b1, "carrier while sending");
		rd_reg(REG_CTRL, s);
		for (j = 0; j < 20000 && far.got_cnt == n0; j++) @(posedge mclk);
		tmo(j, 20000);
		chk_byte(far.got_data, d, "sent data");
		chk_bit(far.got_par, ^d, "sent parity");
		chk_bit(far.got_stop, 1'b1, "sent stop");
	endtask
	task automatic wait_empty;
		logic [7:0] s;
		int j;
		for (j = 0; j < 1000; j++) begin
			rd_reg(REG_CTRL, s);
			if (s[ST_TXEMP] === 1'b1) break;
		end
		tmo(j, 1000);
	endtask
	task automatic line_case(input logic eq, input logic ok, input logic pol, input logic pe,
		input logic exp);
		int n0;
		logic [7:0] s;
		@(posedge mclk);
		equip_check_switch <= eq;
		far_unit_ok_in <= ok;
		paper_polarity_switch <= pol;
		paper_exhausted_in <= pe;
		wr_reg(REG_CTRL, 8'h17);
		n0 = far.got_cnt;
		wr_reg(REG_DATA, 8'hc3);
		tx_wait(n0, 8'hc3, s);
		chk_bit(s[ST_LERR], exp, "line error");
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
		ready_in = 1'b1;
		far_unit_ok_in = 1'b1;
		paper_exhausted_in = 1'b0;
		equip_check_switch = 1'b0;
		carrier_hold_switch = 1'b0;
		paper_polarity_switch = 1'b1;
		num_errors = 0;
		checks = 0;
		repeat (16) @(posedge mclk);
		chk_bit(set_ready_out, 1'b1, "ready in reset");
		chk_bit(txd_out, 1'b1, "line idle in reset");
		chk_bit(xmit_enable_out, 1'b0, "enable in reset");
		rst <= 1'b0;
		@(posedge mclk);
		#1 chk_bit(carrier_detect_out, 1'b0, "carrier after reset");
		$display("test reset done");
		foreach (rows[i]) begin
			set_div(rows[i].div);
			meas();
			lo = 40000000 / (16 * rows[i].rate);
			chk_span(per, lo, lo + 1, "baud period");
			chk_span(hi, per / 2 - 2, per / 2 + 2, "baud high time");
		end
		$display("test divisor table done");
		set_div(16'h0002);
		wr_reg(REG_CTRL, 8'h7e);
		wr_reg(REG_CTRL, 8'h07);
		repeat (2) @(negedge mclk);
		chk_bit(xmit_enable_out, 1'b1, "enable after command");
		chk_bit(set_ready_out, 1'b1, "ready while running");
		c = far.got_cnt;
		wr_reg(REG_DATA, 8'ha5);
		wr_reg(REG_DATA, 8'h3c);
		tx_wait(c, 8'ha5, st);
		tx_wait(c + 1, 8'h3c, st);
		chk_bit(st[ST_LERR], 1'b0, "no line error");
		wait_empty();
		repeat (2) @(negedge mclk);
		chk_bit(carrier_detect_out, 1'b0, "carrier idle");
		@(posedge mclk);
		carrier_hold_switch <= 1'b1;
		repeat (3) @(negedge mclk);
		chk_bit(carrier_detect_out, 1'b1, "carrier held");
		@(posedge mclk);
		carrier_hold_switch <= 1'b0;
		$display("test transmit done");
		@(posedge mclk);
		ready_in <= 1'b0;
		c = far.got_cnt;
		wr_reg(REG_DATA, 8'h5a);
		repeat (3000) @(posedge mclk);
		chk_span(far.got_cnt, c, c, "sent while paused");
		chk_bit(txd_out, 1'b1, "line idle while paused");
		ready_in <= 1'b1;
		tx_wait(c, 8'h5a, st);
		$display("test flow control done");
		line_case(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
		line_case(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		line_case(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
		line_case(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
		@(posedge mclk);
		paper_polarity_switch <= 1'b1;
		wait_empty();
		$display("test line errors done");
		wr_reg(REG_CTRL, 8'h17);
		far.send(8'h3c, 1'b0, 1'b1);
		rd_reg(REG_CTRL, st);
		chk_bit(st[ST_RXRDY], 1'b1, "rx ready");
		chk_bit(st[ST_PE], 1'b0, "no parity error");
		far.send(8'h81, 1'b1, 1'b1);
		rd_reg(REG_CTRL, st);
		chk_bit(st[ST_OE], 1'b1, "overrun");
		chk_bit(st[ST_PE], 1'b1, "parity error");
		rd_reg(REG_DATA, st);
		chk_byte(st, 8'h81, "newest char");
		wr_reg(REG_CTRL, 8'h17);
		far.send(8'h00, 1'b0, 1'b0);
		rd_reg(REG_CTRL, st);
		chk_bit(st[ST_FE], 1'b1, "framing error");
		chk_bit(st[ST_BRK], 1'b1, "break seen");
		$display("test receive done");
		wr_reg(REG_CTRL, 8'h0f);
		repeat (2) @(negedge mclk);
		chk_bit(txd_out, 1'b0, "break sent");
		wr_reg(REG_CTRL, 8'h07);
		repeat (2) @(negedge mclk);
		chk_bit(txd_out, 1'b1, "break ended");
		$display("test break done");
		wrap_up();
	end
endmodule // rsp_serial_port_tb
`default_nettype wire
